/* verification/smf_slave_model.sv */
`timescale 1ns/1ps
module smf_slave_model (
  // Serial pins
  input  wire       serial_clock_out,
  input  wire       master_data_out,
  output wire       master_data_in,
  // Behaviour
  input  wire       invert,
  input  wire       idle_high,
  input  wire       late_sample,
  output reg  [7:0] got_byte
);
  // Sample edge of the selected mode
  wire samp_clk = serial_clock_out ^ idle_high ^ late_sample;
  initial got_byte = 8'h00;
  // Echo slave, no select pin
  assign master_data_in = master_data_out ^ invert;
  // Capture what the master sends, first bit on top
  always @(posedge samp_clk) got_byte <= {got_byte[6:0], master_data_out};
endmodule // smf_slave_model

/* verification/smf_spi_master_props.sv */
`timescale 1ns/1ps
module smf_spi_master_props (
  // Clock, reset, register port
  input wire       mclk,
  input wire       sys_rst,
  input wire [7:0] reg_addr,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // Interrupt and serial pins
  input wire       irq,
  input wire       serial_clock_out,
  input wire       master_data_out,
  input wire       master_data_in
);
  reg [6:0] cfg_q;
  reg [3:0] msk_q;
  // Shadow copies of config and mask
  always @(posedge mclk) begin
    if (sys_rst) begin
      cfg_q <= 7'h02;
      msk_q <= 4'hF;
    end else if (reg_wr && reg_addr == 8'hFC) begin
      cfg_q <= reg_wdata[6:0];
    end else if (reg_wr && reg_addr == 8'hFD) begin
      msk_q <= reg_wdata[3:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_cfg_read: assert property (reg_rd && reg_addr == 8'hFC |=> reg_rdata == {1'b0, cfg_q})
    else $error("config readback wrong");
  a_mask_read: assert property (reg_rd && reg_addr == 8'hFD |=> reg_rdata == {4'h0, msk_q})
    else $error("mask readback wrong");
  a_irq_masked: assert property (msk_q == 4'hF |-> !irq)
    else $error("interrupt while all masked");
  a_stat_flags: assert property (reg_rd && reg_addr == 8'hFE |=>
    reg_rdata[7:4] == 4'h0 && (reg_rdata[2] || !reg_rdata[3]) && (reg_rdata[0] || !reg_rdata[1]))
    else $error("status flags inconsistent");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (reg_rd && reg_addr < 8'hFC |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sck_freeze: assert property ((!cfg_q[0] && $stable(cfg_q))[*2] |=>
    $stable(serial_clock_out) && $stable(master_data_out))
    else $error("serial pins move while disabled");
  a_rate_fast: assert property (cfg_q[0] && !cfg_q[2] && cfg_q[6:4] == 3'h0 && $rose(serial_clock_out)
    |=> $fell(serial_clock_out))
    else $error("half period not one cycle");
  a_rate_div8: assert property (cfg_q[0] && !cfg_q[2] && cfg_q[6:4] == 3'h2 && $rose(serial_clock_out)
    |=> (!$fell(serial_clock_out))[*3] ##1 $fell(serial_clock_out))
    else $error("half period not four cycles");
endmodule // smf_spi_master_props
bind smf_spi_master smf_spi_master_props u_smf_spi_master_props (.mclk(mclk), .sys_rst(sys_rst),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .irq(irq), .serial_clock_out(serial_clock_out), .master_data_out(master_data_out),
  .master_data_in(master_data_in));

/* verification/tb_smf_spi_master.sv */
`timescale 1ns/1ps
module tb_smf_spi_master;
  reg         mclk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [7:0]  reg_addr = 8'h00;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         inv = 1'b0;
  reg         m_cpol = 1'b0;
  reg         m_cpha = 1'b0;
  wire [7:0]  got;
  reg  [16:0] r;
  wire [7:0]  reg_rdata;
  wire        irq;
  wire        sck;
  wire        mosi;
  wire        miso;
  integer     n_fail = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     i;
  // Rows: invert, config, data
  localparam [135:0] ROWS = {17'h001A5, 17'h1133C, 17'h02196, 17'h127C3,
    17'h03D81, 17'h14B7E, 17'h05F18, 17'h16FE7};
  always #50 mclk = ~mclk;
  smf_spi_master u_smf_spi_master (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq(irq), .serial_clock_out(sck),
    .master_data_out(mosi), .master_data_in(miso));
  smf_slave_model u_smf_slave_model (.serial_clock_out(sck), .master_data_out(mosi),
    .master_data_in(miso), .invert(inv), .idle_high(m_cpol), .late_sample(m_cpha), .got_byte(got));
  function [7:0] rev8(input [7:0] v);
    integer b;
    begin
      for (b = 0; b < 8; b = b + 1) rev8[b] = v[7 - b];
    end
  endfunction
  task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0s @%h exp %h got %h", nm, reg_addr, e, g);
      end
    end
  endtask
  task acc(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= w;
      reg_rd <= ~w;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      acc(1'b0, a, 8'h00);
      chk("rdata", e, reg_rdata);
    end
  endtask
  task wst(input [7:0] e);
    integer k;
    begin
      acc(1'b0, 8'hFE, 8'h00);
      for (k = 0; k < 2000 && reg_rdata !== e; k = k + 1) acc(1'b0, 8'hFE, 8'h00);
      chk("status", e, reg_rdata);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(8'hFC, 8'h02);
    rd(8'hFD, 8'h0F);
    rd(8'hFE, 8'h03);
    rd(8'hFF, 8'h00);
    rd(8'h10, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      r = ROWS[i*17 +: 17];
      inv = r[16];
      m_cpol = r[10];
      m_cpha = r[9];
      acc(1'b1, 8'hFC, r[15:8]);
      acc(1'b1, 8'hFF, r[7:0]);
      acc(1'b1, 8'hFF, ~r[7:0]);
      wst(8'h0F);
      chk("slave", r[11] ? rev8(~r[7:0]) : ~r[7:0], got);
      chk("sck", {7'h00, r[10]}, {7'h00, sck});
      rd(8'hFF, r[7:0] ^ {8{r[16]}});
      rd(8'hFE, 8'h07);
      rd(8'hFF, ~r[7:0] ^ {8{r[16]}});
      rd(8'hFE, 8'h03);
    end
    inv = 1'b0;
    acc(1'b1, 8'hFC, 8'h00);
    acc(1'b1, 8'hFF, 8'h11);
    acc(1'b1, 8'hFF, 8'h22);
    acc(1'b1, 8'hFF, 8'h33);
    rd(8'hFE, 8'h00);
    acc(1'b1, 8'hFC, 8'h01);
    wst(8'h0F);
    acc(1'b1, 8'hFF, 8'h66);
    repeat (50) @(posedge mclk);
    rd(8'hFE, 8'h0D);
    acc(1'b1, 8'hFD, 8'h07);
    chk("irq", 8'h01, {7'h00, irq});
    rd(8'hFF, 8'h11);
    chk("irq", 8'h00, {7'h00, irq});
    wst(8'h0F);
    acc(1'b1, 8'hFD, 8'h0F);
    chk("irq", 8'h00, {7'h00, irq});
    rd(8'hFF, 8'h22);
    rd(8'hFF, 8'h66);
    rd(8'hFF, 8'h00);
    acc(1'b1, 8'hFC, 8'h71);
    acc(1'b1, 8'hFF, 8'h5A);
    repeat (300) @(posedge mclk);
    acc(1'b1, 8'hFC, 8'h70);
    repeat (2000) @(posedge mclk);
    rd(8'hFE, 8'h03);
    acc(1'b1, 8'hFC, 8'h71);
    wst(8'h07);
    rd(8'hFF, 8'h5A);
    end_sim;
  end
endmodule // tb_smf_spi_master

/* verilog/smf_defines.vh */
`ifndef SMF_DEFINES_VH
`define SMF_DEFINES_VH
// Register addresses
`define SMF_ADDR_CONFIG   8'hFC
`define SMF_ADDR_MASK     8'hFD
`define SMF_ADDR_STATUS   8'hFE
`define SMF_ADDR_DATA     8'hFF
// Config fields
`define SMF_CFG_EN        0
`define SMF_CFG_CPHA      1
`define SMF_CFG_CPOL      2
`define SMF_CFG_LSB       3
`define SMF_CFG_RATE_HI   6
`define SMF_CFG_RATE_LO   4
// Status fields
`define SMF_ST_TX_SPACE   0
`define SMF_ST_TX_EMPTY   1
`define SMF_ST_RX_AVAIL   2
`define SMF_ST_RX_FULL    3
// Reset values
`define SMF_RST_CONFIG    7'h02
`define SMF_RST_MASK      4'hF
`define SMF_RST_STATUS    4'h3
// Depths
`define SMF_FIFO_DEPTH    2'h2
`endif

/* verilog/smf_spi_master.v */
`timescale 1ns/1ps
`include "smf_defines.vh"
module smf_spi_master (
  // Clock and reset
  input  wire       mclk,
  input  wire       sys_rst,
  // Register port
  input  wire [7:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  // Interrupt
  output wire       irq,
  // Serial pins
  output reg        serial_clock_out,
  output reg        master_data_out,
  input  wire       master_data_in
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [6:0] spi_master_config_q;
  reg  [3:0] spi_master_irq_mask_q;
  wire       master_enable    = spi_master_config_q[`SMF_CFG_EN];
  wire       clock_phase_b    = spi_master_config_q[`SMF_CFG_CPHA];
  wire       clock_polarity_a = spi_master_config_q[`SMF_CFG_CPOL];
  wire       bit_order        = spi_master_config_q[`SMF_CFG_LSB];
  wire [2:0] serial_clock_rate = spi_master_config_q[`SMF_CFG_RATE_HI:`SMF_CFG_RATE_LO];

  wire wr_cfg  = reg_wr && (reg_addr == `SMF_ADDR_CONFIG);
  wire wr_mask = reg_wr && (reg_addr == `SMF_ADDR_MASK);
  wire wr_data = reg_wr && (reg_addr == `SMF_ADDR_DATA);
  wire rd_data = reg_rd && (reg_addr == `SMF_ADDR_DATA);

  always @(posedge mclk) begin
    if (sys_rst) begin
      spi_master_config_q   <= `SMF_RST_CONFIG;
      spi_master_irq_mask_q <= `SMF_RST_MASK;
    end else begin
      if (wr_cfg)
        spi_master_config_q <= reg_wdata[6:0];
      if (wr_mask)
        spi_master_irq_mask_q <= reg_wdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit FIFO
  reg  [7:0] tx_mem [0:1];
  reg        tx_wp_q;
  reg        tx_rp_q;
  reg  [1:0] tx_cnt_q;
  wire       tx_full  = (tx_cnt_q == `SMF_FIFO_DEPTH);
  wire       tx_empty = (tx_cnt_q == 2'h0);
  wire       tx_push  = wr_data && !tx_full;
  wire       tx_pop;

  always @(posedge mclk) begin
    if (sys_rst) begin
      tx_wp_q  <= 1'b0;
      tx_rp_q  <= 1'b0;
      tx_cnt_q <= 2'h0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_q] <= reg_wdata;
        tx_wp_q         <= ~tx_wp_q;
      end
      if (tx_pop)
        tx_rp_q <= ~tx_rp_q;
      if (tx_push && !tx_pop)
        tx_cnt_q <= tx_cnt_q + 2'h1;
      else if (tx_pop && !tx_push)
        tx_cnt_q <= tx_cnt_q - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO
  reg  [7:0] rx_mem [0:1];
  reg        rx_wp_q;
  reg        rx_rp_q;
  reg  [1:0] rx_cnt_q;
  wire       rx_full  = (rx_cnt_q == `SMF_FIFO_DEPTH);
  wire       rx_empty = (rx_cnt_q == 2'h0);
  wire       rx_pop   = rd_data && !rx_empty;
  wire       rx_push;
  wire [7:0] rx_byte;

  always @(posedge mclk) begin
    if (sys_rst) begin
      rx_wp_q  <= 1'b0;
      rx_rp_q  <= 1'b0;
      rx_cnt_q <= 2'h0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_q] <= rx_byte;
        rx_wp_q         <= ~rx_wp_q;
      end
      if (rx_pop)
        rx_rp_q <= ~rx_rp_q;
      if (rx_push && !rx_pop)
        rx_cnt_q <= rx_cnt_q + 2'h1;
      else if (rx_pop && !rx_push)
        rx_cnt_q <= rx_cnt_q - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and interrupt
  wire [3:0] status;
  assign status[`SMF_ST_RX_FULL]  = rx_full;
  assign status[`SMF_ST_RX_AVAIL] = !rx_empty;
  assign status[`SMF_ST_TX_EMPTY] = tx_empty;
  assign status[`SMF_ST_TX_SPACE] = !tx_full;
  assign irq = |(status & ~spi_master_irq_mask_q);

  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `SMF_ADDR_CONFIG)
        reg_rdata <= {1'b0, spi_master_config_q};
      else if (reg_addr == `SMF_ADDR_MASK)
        reg_rdata <= {4'h0, spi_master_irq_mask_q};
      else if (reg_addr == `SMF_ADDR_STATUS)
        reg_rdata <= {4'h0, status};
      else if (reg_addr == `SMF_ADDR_DATA)
        reg_rdata <= rx_empty ? 8'h00 : rx_mem[rx_rp_q];
      else
        reg_rdata <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial engine state
  localparam ST_IDLE = 1'b0;
  localparam ST_XFER = 1'b1;
  reg        state_q;
  reg  [5:0] div_q;
  reg  [5:0] half_lim;
  reg  [7:0] sh_q;
  reg  [7:0] rxs_q;
  reg  [3:0] edge_q;
  reg        sclk_act_q;
  reg        mosi_q;
  reg        din_meta_q;
  reg        din_sync_q;
  reg  [2:0] samp_pipe_q;
  reg  [2:0] last_pipe_q;
  wire [7:0] tx_head    = tx_mem[tx_rp_q];
  wire       tick       = (div_q == half_lim);
  wire       tail_busy  = |last_pipe_q;
  wire       start      = master_enable && !tx_empty && !rx_full && !tail_busy;
  wire       last_edge  = (edge_q == 4'hF);
  wire       run        = master_enable && (state_q == ST_XFER) && tick;
  wire       lead       = !edge_q[0];
  wire       sample_now = clock_phase_b ? !lead : lead;
  wire [7:0] rx_next    = bit_order ? {din_sync_q, rxs_q[7:1]} : {rxs_q[6:0], din_sync_q};
  assign tx_pop  = (state_q == ST_IDLE) && start;
  assign rx_byte = samp_pipe_q[2] ? rx_next : rxs_q;
  assign rx_push = last_pipe_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Input synchroniser
  always @(posedge mclk) begin
    if (sys_rst) begin
      din_meta_q <= 1'b0;
      din_sync_q <= 1'b0;
    end else begin
      din_meta_q <= master_data_in;
      din_sync_q <= din_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider: half period of 2^rate cycles, 32 cycles for rates 5 to 7
  always @* begin
    case (serial_clock_rate)
      3'h0:    half_lim = 6'h00;
      3'h1:    half_lim = 6'h01;
      3'h2:    half_lim = 6'h03;
      3'h3:    half_lim = 6'h07;
      3'h4:    half_lim = 6'h0F;
      default: half_lim = 6'h1F;
    endcase
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      div_q <= 6'h00;
    end else if (!master_enable || state_q == ST_IDLE || tick) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencing and edge count
  always @(posedge mclk) begin
    if (sys_rst) begin
      state_q    <= ST_IDLE;
      edge_q     <= 4'h0;
      sclk_act_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          edge_q     <= 4'h0;
          sclk_act_q <= 1'b0;
          if (tx_pop) begin
            state_q <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (run) begin
            edge_q     <= edge_q + 4'h1;
            sclk_act_q <= ~sclk_act_q;
            if (last_edge) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter
  always @(posedge mclk) begin
    if (sys_rst) begin
      sh_q   <= 8'h00;
      mosi_q <= 1'b0;
    end else if (tx_pop) begin
      if (clock_phase_b) begin
        sh_q <= tx_head;
      end else begin
        mosi_q <= bit_order ? tx_head[0] : tx_head[7];
        sh_q   <= bit_order ? {1'b0, tx_head[7:1]} : {tx_head[6:0], 1'b0};
      end
    end else if (run && !sample_now) begin
      mosi_q <= bit_order ? sh_q[0] : sh_q[7];
      sh_q   <= bit_order ? {1'b0, sh_q[7:1]} : {sh_q[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive sampling, delayed for pin lag and synchroniser
  always @(posedge mclk) begin
    if (sys_rst) begin
      samp_pipe_q <= 3'h0;
      last_pipe_q <= 3'h0;
    end else begin
      samp_pipe_q <= {samp_pipe_q[1:0], run && sample_now};
      last_pipe_q <= {last_pipe_q[1:0], run && last_edge};
    end
  end

  always @(posedge mclk) begin
    if (sys_rst) begin
      rxs_q <= 8'h00;
    end else if (samp_pipe_q[2]) begin
      rxs_q <= rx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin registers, clock and data aligned
  always @(posedge mclk) begin
    if (sys_rst) begin
      serial_clock_out <= 1'b0;
      master_data_out  <= 1'b0;
    end else begin
      serial_clock_out <= sclk_act_q ^ clock_polarity_a;
      master_data_out  <= mosi_q;
    end
  end

endmodule // smf_spi_master
